/* adst_sample_cfg.sv */
// sample time configuration for channels 10 to 17, avalon slave
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "adst_defs.svh"

// Overview of operation
// - bits 31..24 reserved: read zero, writes ignored there
// - bits 23..21 hold channel 17 sampling code, reset zero
// - bits 20..18 hold channel 16 sampling code, reset zero
// - bits 17..15 hold channel 15 sampling code, reset zero
// - bits 14..12 hold channel 14 sampling code, reset zero
// - bits 11..9 hold channel 13 sampling code, reset zero
// - bits 8..6 hold channel 12 sampling code, reset zero
// - bits 5..3 hold channel 11 sampling code, reset zero
// - bits 2..0 channel 10; codes give 1.5 to 239.5 cycles
module adst_sample_cfg (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire adst_pkg::adst_avs_req_t avs_req,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic conv_start,
   input wire logic [4:0] conv_channel,
   output adst_pkg::adst_cfg_t sample_cfg,
   output logic sampling,
   output logic sample_done
);
   import adst_pkg::*;

   adst_state_t r;
   adst_state_t next_r;
   logic wr_cfg;
   logic [31:0] wd;

   // pick the code of a channel of this bank
   function automatic logic [2:0] code_of(input adst_cfg_t c,
                                          input logic [4:0] ch);
      unique case (ch)
         5'h0A: code_of = c.sample_len_ch10;
         5'h0B: code_of = c.sample_len_ch11;
         5'h0C: code_of = c.sample_len_ch12;
         5'h0D: code_of = c.sample_len_ch13;
         5'h0E: code_of = c.sample_len_ch14;
         5'h0F: code_of = c.sample_len_ch15;
         5'h10: code_of = c.sample_len_ch16;
         default: code_of = c.sample_len_ch17;
      endcase
   endfunction : code_of

   // write takes effect at the edge where waitrequest is low
   assign wd = avs_req.writedata;
   assign wr_cfg = avs_req.write && !r.waitrequest
      && avs_req.address == `ADST_IDX_CFG
      && avs_req.byteenable == `ADST_FULL_WORD;

   // next state: bus slave and sampling timer
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.waitrequest = !((avs_req.read || avs_req.write)
         && r.waitrequest);
      if (avs_req.read && r.waitrequest) begin
         unique case (avs_req.address)
            `ADST_IDX_CFG: next_r.rdata = {`ADST_RSVD_VAL, r.cfg};
            `ADST_IDX_STATUS: begin
               next_r.rdata = 32'h00000000;
               next_r.rdata[`ADST_ST_SAMPLING] = r.sampling;
               next_r.rdata[`ADST_ST_CH_LSB +: 5] = r.ch;
            end
            default: next_r.rdata = 32'h00000000;
         endcase
      end
      // reserved bits 31..24 are never stored
      if (wr_cfg) begin
         next_r.cfg.sample_len_ch17 = wd[`ADST_CH17_LSB +: `ADST_FIELD_W];
         next_r.cfg.sample_len_ch16 = wd[`ADST_CH16_LSB +: `ADST_FIELD_W];
         next_r.cfg.sample_len_ch15 = wd[`ADST_CH15_LSB +: `ADST_FIELD_W];
         next_r.cfg.sample_len_ch14 = wd[`ADST_CH14_LSB +: `ADST_FIELD_W];
         next_r.cfg.sample_len_ch13 = wd[`ADST_CH13_LSB +: `ADST_FIELD_W];
         next_r.cfg.sample_len_ch12 = wd[`ADST_CH12_LSB +: `ADST_FIELD_W];
         next_r.cfg.sample_len_ch11 = wd[`ADST_CH11_LSB +: `ADST_FIELD_W];
         next_r.cfg.sample_len_ch10 = wd[`ADST_CH10_LSB +: `ADST_FIELD_W];
      end
      // sampling phase timer, code chosen at the start
      unique case (r.fsm)
         ADST_IDLE: begin
            if (conv_start && conv_channel >= `ADST_CH_FIRST
                && conv_channel <= `ADST_CH_LAST) begin
               next_r.ch = conv_channel;
               next_r.cnt = adst_cycles(code_of(r.cfg, conv_channel))
                  - 8'h01;
               next_r.sampling = 1'b1;
               next_r.fsm = ADST_SAMPLE;
            end
         end
         ADST_SAMPLE: begin
            if (r.cnt == 8'h00) begin
               next_r.sampling = 1'b0;
               next_r.done = 1'b1;
               next_r.fsm = ADST_IDLE;
            end else begin
               next_r.cnt = r.cnt - 8'h01;
            end
         end
         default: begin
            next_r.fsm = ADST_IDLE;
            next_r.sampling = 1'b0;
         end
      endcase
   end

   // state register, frozen while ce is low
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         r <= '{waitrequest: 1'b1, rdata: 32'h00000000,
                cfg: `ADST_CFG_RST, fsm: ADST_IDLE, cnt: 8'h00,
                ch: 5'h00, sampling: 1'b0, done: 1'b0};
      end else if (ce) begin
         r <= next_r;
      end
   end

   // outputs straight from the state register
   assign avs_readdata = r.rdata;
   assign avs_waitrequest = r.waitrequest;
   assign sample_cfg = r.cfg;
   assign sampling = r.sampling;
   assign sample_done = r.done;

   // helpers: length of the running sampling phase and its code
   logic [7:0] h_len;
   logic [2:0] h_code;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         h_len <= 8'h00;
         h_code <= 3'h0;
      end else if (ce) begin
         if (r.fsm == ADST_IDLE) begin
            h_len <= 8'h00;
            h_code <= code_of(r.cfg, conv_channel);
         end else begin
            h_len <= h_len + 8'h01;
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_rsvd_read_zero: assert property (
      !avs_waitrequest |-> avs_readdata[31:24] == `ADST_RSVD_VAL)
      else $error("reserved bits read nonzero");
   a_ch17_write: assert property (
      ce && wr_cfg |=> sample_cfg.sample_len_ch17
         == $past(wd[`ADST_CH17_LSB +: `ADST_FIELD_W]))
      else $error("ch17 code not stored");
   a_ch16_write: assert property (
      ce && wr_cfg |=> sample_cfg.sample_len_ch16
         == $past(wd[`ADST_CH16_LSB +: `ADST_FIELD_W]))
      else $error("ch16 code not stored");
   a_ch15_write: assert property (
      ce && wr_cfg |=> sample_cfg.sample_len_ch15
         == $past(wd[`ADST_CH15_LSB +: `ADST_FIELD_W]))
      else $error("ch15 code not stored");
   a_ch14_hold: assert property (
      !(ce && wr_cfg) |=> $stable(sample_cfg.sample_len_ch14))
      else $error("ch14 code changed without write");
   a_ch13_write: assert property (
      ce && wr_cfg |=> sample_cfg.sample_len_ch13
         == $past(wd[`ADST_CH13_LSB +: `ADST_FIELD_W]))
      else $error("ch13 code not stored");
   a_ch12_readback: assert property (
      ce && avs_req.read && avs_waitrequest
         && avs_req.address == `ADST_IDX_CFG
      |=> avs_readdata[`ADST_CH12_LSB +: `ADST_FIELD_W]
         == $past(sample_cfg.sample_len_ch12) && !avs_waitrequest)
      else $error("ch12 readback wrong");
   a_ch11_write: assert property (
      ce && wr_cfg |=> sample_cfg.sample_len_ch11
         == $past(wd[`ADST_CH11_LSB +: `ADST_FIELD_W]))
      else $error("ch11 code not stored");
   a_sample_len_exact: assert property (
      ce && r.fsm == ADST_SAMPLE && r.cnt == 8'h00
      |-> h_len + 8'h01 == adst_cycles(h_code))
      else $error("sampling length differs from code");
   a_sample_starts: assert property (
      ce && !sampling && conv_start && conv_channel >= `ADST_CH_FIRST
         && conv_channel <= `ADST_CH_LAST
      |=> sampling && r.ch == $past(conv_channel))
      else $error("sampling phase did not start");
   a_done_after_phase: assert property (
      $past(ce) && sample_done |-> $past(sampling) && !sampling)
      else $error("done pulse without sampling phase");

   // remaining fields, refused writes, bus answer and the freeze
   a_ch14_write: assert property (
      ce && wr_cfg |=> sample_cfg.sample_len_ch14
         == $past(wd[`ADST_CH14_LSB +: `ADST_FIELD_W]))
      else $error("ch14 code not stored");
   a_ch10_write: assert property (
      ce && wr_cfg |=> sample_cfg.sample_len_ch10
         == $past(wd[`ADST_CH10_LSB +: `ADST_FIELD_W]))
      else $error("ch10 code not stored");
   a_partial_refused: assert property (
      ce && avs_req.write && !avs_waitrequest
         && avs_req.byteenable != `ADST_FULL_WORD |=> $stable(sample_cfg))
      else $error("partial write changed the codes");
   a_bus_answer: assert property (
      ce && (avs_req.read || avs_req.write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("bus access not answered in one cycle");
   a_timer_freeze: assert property (
      !ce |=> $stable(r))
      else $error("state moved while ce was low");

   // cover points for the main scenarios
   c_cfg_write: cover property (ce && wr_cfg);
   c_long_sample: cover property (sample_done && h_code == 3'h7);
   c_partial_refused: cover property (avs_req.write && !avs_waitrequest
      && avs_req.byteenable != `ADST_FULL_WORD);
   c_status_read: cover property (!avs_waitrequest && avs_req.read
      && avs_req.address == `ADST_IDX_STATUS);

endmodule : adst_sample_cfg
`default_nettype wire

/* adst_defs.svh */
// register map, field positions, reset values and sampling lengths
`ifndef ADST_DEFS_SVH
`define ADST_DEFS_SVH

// word addresses of the registers
`define ADST_ADDR_W 2
`define ADST_IDX_CFG 2'h0
`define ADST_IDX_STATUS 2'h1

// configuration register layout
`define ADST_FIELD_W 3
`define ADST_RSVD_LSB 24
`define ADST_CH17_LSB 21
`define ADST_CH16_LSB 18
`define ADST_CH15_LSB 15
`define ADST_CH14_LSB 12
`define ADST_CH13_LSB 9
`define ADST_CH12_LSB 6
`define ADST_CH11_LSB 3
`define ADST_CH10_LSB 0
`define ADST_CFG_RST 24'h000000
`define ADST_RSVD_VAL 8'h00
`define ADST_FULL_WORD 4'hF

// status register layout
`define ADST_ST_SAMPLING 0
`define ADST_ST_CH_LSB 4

// first and last channel held by this register
`define ADST_CH_FIRST 5'h0A
`define ADST_CH_LAST 5'h11

// sampling lengths in tenths of a converter cycle, as printed
`define ADST_SPT_X10_0 15
`define ADST_SPT_X10_1 75
`define ADST_SPT_X10_2 135
`define ADST_SPT_X10_3 285
`define ADST_SPT_X10_4 415
`define ADST_SPT_X10_5 555
`define ADST_SPT_X10_6 715
`define ADST_SPT_X10_7 2395

`endif

/* adst_pkg.sv */
// types and the sampling length lookup of the sample time block
`include "adst_defs.svh"
package adst_pkg;

   // one avalon request
   typedef struct packed {
      logic read;
      logic write;
      logic [`ADST_ADDR_W-1:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } adst_avs_req_t;

   // eight codes, ch17 in the top bits
   typedef struct packed {
      logic [2:0] sample_len_ch17;
      logic [2:0] sample_len_ch16;
      logic [2:0] sample_len_ch15;
      logic [2:0] sample_len_ch14;
      logic [2:0] sample_len_ch13;
      logic [2:0] sample_len_ch12;
      logic [2:0] sample_len_ch11;
      logic [2:0] sample_len_ch10;
   } adst_cfg_t;

   typedef enum logic [1:0] {
      ADST_IDLE = 2'b01,
      ADST_SAMPLE = 2'b10
   } adst_fsm_t;

   typedef struct packed {
      logic waitrequest;
      logic [31:0] rdata;
      adst_cfg_t cfg;
      adst_fsm_t fsm;
      logic [7:0] cnt;
      logic [4:0] ch;
      logic sampling;
      logic done;
   } adst_state_t;

   // whole clock cycles of sampling, half cycles rounded up
   function automatic logic [7:0] adst_cycles(input logic [2:0] code);
      int x10;
      unique case (code)
         3'h0: x10 = `ADST_SPT_X10_0;
         3'h1: x10 = `ADST_SPT_X10_1;
         3'h2: x10 = `ADST_SPT_X10_2;
         3'h3: x10 = `ADST_SPT_X10_3;
         3'h4: x10 = `ADST_SPT_X10_4;
         3'h5: x10 = `ADST_SPT_X10_5;
         3'h6: x10 = `ADST_SPT_X10_6;
         3'h7: x10 = `ADST_SPT_X10_7;
      endcase
      return 8'((x10 + 9) / 10);
   endfunction : adst_cycles

endpackage : adst_pkg

/* adc_sample_time_select_high_bench.sv */
// self-checking bench for the upper sample time configuration block
`timescale 1ns/1ps
`default_nettype none
module adc_sample_time_select_high_bench;
   import adst_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   adst_avs_req_t req = '0;
   logic conv_start = 1'b0;
   logic [4:0] conv_channel = 5'h00;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   adst_cfg_t sample_cfg;
   logic sampling;
   logic sample_done;
   int err_count = 0;
   int checked = 0;
   int cycles = 0;
   int w;
   logic [31:0] rd;
   logic [31:0] cw;
   // written words beside the readback they should give
   logic [31:0] rows_w [4] = '{32'hFFFFFFFF, 32'h5A5A5A5A, 32'h00924924,
      32'h12345678};
   logic [31:0] rows_e [4] = '{32'h00FFFFFF, 32'h005A5A5A, 32'h00924924,
      32'h00345678};
   // 1.5 .. 239.5 converter cycles, half cycles rounded up
   int nlen [8] = '{2, 8, 14, 29, 42, 56, 72, 240};

   adst_sample_cfg adst_sample_cfg_i (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .avs_req(req),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .conv_start(conv_start),
      .conv_channel(conv_channel),
      .sample_cfg(sample_cfg),
      .sampling(sampling),
      .sample_done(sample_done)
   );

   // 50 mhz clock
   always #10 ref_clk = ~ref_clk;

   task automatic close_out();
      if (err_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   // hang guard
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one avalon access, held until waitrequest is sampled low at an edge
   task automatic acc(input logic wr, input logic [1:0] a,
         input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge ref_clk);
      req.read <= ~wr;
      req.write <= wr;
      req.address <= a;
      req.writedata <= d;
      req.byteenable <= be;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         n++;
         @(posedge ref_clk);
      end
      if (n == 50) err_count++;
      rd = avs_readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask : acc

   // one-cycle start pulse
   task automatic start(input logic [4:0] ch);
      @(posedge ref_clk);
      conv_start <= 1'b1;
      conv_channel <= ch;
      @(posedge ref_clk);
      conv_start <= 1'b0;
   endtask : start

   // count cycles of the sampling phase
   task automatic measure(input int n);
      int c;
      c = 0;
      @(negedge ref_clk);
      while (sampling === 1'b1 && c < 300) begin
         c++;
         @(negedge ref_clk);
      end
      chk(32'(c), 32'(n));
      chk({31'h0, sample_done}, 32'h00000001);
   endtask : measure

   initial begin
      repeat (20) @(posedge ref_clk);
      chk({31'h0, avs_waitrequest}, 32'h00000001);
      chk({8'h00, sample_cfg}, 32'h00000000);
      rst <= 1'b0;
      acc(1'b0, 2'h0, 32'h0, 4'hF);
      chk(rd, 32'h00000000);
      // row table: write, read back, compare config outputs
      foreach (rows_w[i]) begin
         acc(1'b1, 2'h0, rows_w[i], 4'hF);
         acc(1'b0, 2'h0, 32'h0, 4'hF);
         chk(rd, rows_e[i]);
         chk({8'h00, sample_cfg}, rows_e[i]);
      end
      // partial and misaddressed writes leave the word alone
      acc(1'b1, 2'h0, 32'h00000000, 4'h7);
      acc(1'b1, 2'h3, 32'h00000000, 4'hF);
      acc(1'b0, 2'h0, 32'h0, 4'hF);
      chk(rd, 32'h00345678);
      acc(1'b0, 2'h2, 32'h0, 4'hF);
      chk(rd, 32'h00000000);
      // channel 10+i gets code i, then every channel is sampled
      cw = 32'h0;
      for (int i = 0; i < 8; i++) cw |= 32'(i) << (3 * i);
      acc(1'b1, 2'h0, cw, 4'hF);
      for (int i = 0; i < 8; i++) begin
         start(5'(10 + i));
         measure(nlen[i]);
      end
      // a start during sampling is ignored
      start(5'h11);
      start(5'h0A);
      acc(1'b0, 2'h1, 32'h0, 4'hF);
      chk(rd, 32'h00000111);
      w = 0;
      while (sample_done !== 1'b1 && w < 300) begin
         w++;
         @(negedge ref_clk);
      end
      chk({31'h0, sample_done}, 32'h00000001);
      repeat (2) @(negedge ref_clk);
      chk({31'h0, sampling}, 32'h00000000);
      // channels outside 10..17 start nothing
      start(5'h09);
      start(5'h12);
      @(negedge ref_clk);
      chk({31'h0, sampling}, 32'h00000000);
      // ce low stretches a running phase by the frozen cycles
      start(5'h0B);
      @(posedge ref_clk);
      ce <= 1'b0;
      repeat (5) @(posedge ref_clk);
      chk({31'h0, sampling}, 32'h00000001);
      ce <= 1'b1;
      measure(7);
      // a start while ce is low is not taken
      @(posedge ref_clk);
      ce <= 1'b0;
      start(5'h0A);
      @(negedge ref_clk);
      chk({31'h0, sampling}, 32'h00000000);
      @(posedge ref_clk);
      ce <= 1'b1;
      // second reset clears the word
      @(posedge ref_clk);
      rst <= 1'b1;
      @(negedge ref_clk);
      chk({8'h00, sample_cfg}, 32'h00000000);
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      acc(1'b0, 2'h0, 32'h0, 4'hF);
      chk(rd, 32'h00000000);
      close_out();
   end
endmodule : adc_sample_time_select_high_bench
`default_nettype wire
